/* File: rtl/dorc_core.sv */
// Discrete output run control: channel gating, status words and AXI4-Lite registers
// How it works
// - After reset every channel stays off until host communication is valid and Run is seen.
// - Before Run the input assembly is not published and no channel is driven.
// - Outside Run all channels are forced off whatever the control bits hold.
// - Host control values are loaded into the output latch only when Run is entered or held.
// - In Run with no fault each channel follows its control bit, one on and zero off.
// - A hardware fault turns every channel off and freezes the last channel status; module status keeps following the fault pins.
// - Host data is 16-bit words: three input words, two output words, no configuration.
// - Channel status is the state read back from the output logic, not the control echo.
// - A channel enabled in Run shows its status bit set through that readback.
// - Module status bit 0 flags a failed link to the output logic, a hardware fault.
// - Module status bit 1 flags a supply brownout, a hardware fault.
// - Module status bit 8 flags a bad serial checksum and blocks normal operation.
// - Module status bits 7:2 and 14:9 always read zero.
// - Module status bit 15 is the OR of the three fault bits and forces outputs off.
// - Critical and non-critical errors are reported to the host.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dorc_cfg.svh"
module dorc_core #(
    parameter int NUM_CH = `DORC_NUM_CH
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    reset_i,
    // AXI4-Lite slave
    input  wire logic [`DORC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`DORC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // Output logic side
    output logic [NUM_CH-1:0]            chan_drive_o,
    input  wire logic [NUM_CH-1:0]       chan_readback_i,
    input  wire logic                    link_fault_i,
    input  wire logic                    brownout_flag_i,
    input  wire logic                    serial_invalid_flag_i,
    output logic                         irq_o
);
    logic [NUM_CH-1:0] rb_s;
    logic [2:0]        flt_s;

    // Readback and fault pins cross in here; logic reads only the synchronised copies
    dorc_sync2 #(.W(NUM_CH)) u_sync_rb (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    (chan_readback_i),
        .sync_o     (rb_s)
    );

    dorc_sync2 #(.W(3)) u_sync_flt (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    ({serial_invalid_flag_i, brownout_flag_i, link_fault_i}),
        .sync_o     (flt_s)
    );

    // Registers
    dorc_pkg::dorc_mode_t         mode_r, mode_nxt;
    logic [NUM_CH-1:0]            output_control_variable_r;
    logic [NUM_CH-1:0]            out_latch_r;
    logic [NUM_CH-1:0]            channel_readback_status_r;
    logic [`DORC_WORD_W-1:0]      module_fault_status_r;
    logic [1:0]                   host_ctrl_r;
    logic [`DORC_IRQ_W-1:0]       irq_stat_r;
    logic [`DORC_IRQ_W-1:0]       irq_mask_r;
    logic                         noncrit_r;

    // Fault decode
    wire logic link_fault   = flt_s[0];
    wire logic brownout     = flt_s[1];
    wire logic serial_bad   = flt_s[2];
    // A bad serial checksum counts as a fault so an uncalibrated part never drives
    wire logic hw_fault     = link_fault | brownout | serial_bad;
    wire logic comm_ok      = host_ctrl_r[`DORC_HC_COMM_OK];
    wire logic run_req      = host_ctrl_r[`DORC_HC_RUN];
    wire logic in_run       = (mode_r == dorc_pkg::DORC_ST_RUN);

    // Mode sequencing: Run needs established communication first
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            dorc_pkg::DORC_ST_WAIT_COMM: begin
                if (comm_ok) begin
                    mode_nxt = dorc_pkg::DORC_ST_IDLE;
                end
            end
            dorc_pkg::DORC_ST_IDLE: begin
                if (!comm_ok) begin
                    mode_nxt = dorc_pkg::DORC_ST_WAIT_COMM;
                end else if (run_req) begin
                    mode_nxt = dorc_pkg::DORC_ST_RUN;
                end
            end
            // Losing communication ends Run at once, which drops every channel
            dorc_pkg::DORC_ST_RUN: begin
                if (!comm_ok) begin
                    mode_nxt = dorc_pkg::DORC_ST_WAIT_COMM;
                end else if (!run_req) begin
                    mode_nxt = dorc_pkg::DORC_ST_IDLE;
                end
            end
            default: mode_nxt = dorc_pkg::DORC_ST_WAIT_COMM;
        endcase
    end

    // Control values only pass to the latch in Run; outside Run the latch is cleared
    wire logic [NUM_CH-1:0] latch_nxt =
        in_run ? output_control_variable_r : {NUM_CH{1'b0}};
    // Drive gated per channel by Run and by the fault summary
    wire logic [NUM_CH-1:0] drive_nxt;
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_gate
        assign drive_nxt[ch] = in_run & ~hw_fault & out_latch_r[ch];
    end

    // Module status follows the fault pins; channel status is the part that freezes
    wire logic [`DORC_WORD_W-1:0] mod_stat_nxt = build_mod_stat(link_fault, brownout, serial_bad);

    function automatic logic [`DORC_WORD_W-1:0] build_mod_stat(
        input logic lnk, input logic pwr, input logic ser);
        logic [`DORC_WORD_W-1:0] w;
        w = `DORC_ZERO16;
        w[`DORC_BIT_LINK_FAULT] = lnk;
        w[`DORC_BIT_BROWNOUT]   = pwr;
        w[`DORC_BIT_SERIAL]     = ser;
        w[`DORC_BIT_MOD_FAULT]  = lnk | pwr | ser;
        return w;
    endfunction : build_mod_stat

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_r                    <= dorc_pkg::DORC_ST_WAIT_COMM;
            out_latch_r               <= '0;
            chan_drive_o              <= '0;
            channel_readback_status_r <= '0;
            module_fault_status_r     <= `DORC_ZERO16;
        end else begin
            mode_r       <= mode_nxt;
            out_latch_r  <= latch_nxt;
            chan_drive_o <= drive_nxt;
            if (!hw_fault) begin
                channel_readback_status_r <= rb_s;
            end
            // Fault bits keep updating so the new fault itself is recorded
            module_fault_status_r <= mod_stat_nxt;
        end
    end

    // Interrupt events
    logic in_run_d_r;
    logic hw_fault_d_r;
    wire logic ev_fault   = hw_fault & ~hw_fault_d_r;
    wire logic ev_run_in  = in_run & ~in_run_d_r;
    wire logic ev_run_out = ~in_run & in_run_d_r;
    wire logic [`DORC_IRQ_W-1:0] ev_vec = {noncrit_r, ev_run_out, ev_run_in, ev_fault};

    // AXI4-Lite write path: address and data may arrive in either order
    logic                    aw_held_r, w_held_r;
    logic [`DORC_ADDR_W-1:0] aw_addr_r;
    logic [31:0]             w_data_r;
    logic [3:0]              w_strb_r;
    wire logic aw_take  = s_axi_awvalid & s_axi_awready;
    wire logic w_take   = s_axi_wvalid & s_axi_wready;
    wire logic wr_fire  = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire logic wr_ctrl  = wr_fire && aw_addr_r == `DORC_OFS_CTRL;
    wire logic wr_hc    = wr_fire && aw_addr_r == `DORC_OFS_HOST_CTRL;
    wire logic wr_mask  = wr_fire && aw_addr_r == `DORC_OFS_IRQ_MASK;
    wire logic wr_hit   = wr_ctrl | wr_hc | wr_mask;

    function automatic logic [31:0] strb_merge(
        input logic [31:0] old_v, input logic [31:0] new_v, input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : strb_merge

    wire logic [31:0] ctrl_merged = strb_merge(output_control_variable_r, w_data_r, w_strb_r);
    wire logic [31:0] hc_merged   = strb_merge({30'h0000_0000, host_ctrl_r}, w_data_r, w_strb_r);
    wire logic [31:0] mask_merged =
        strb_merge({28'h000_0000, irq_mask_r}, w_data_r, w_strb_r);

    // Read path
    logic                    rd_busy_r;
    wire logic ar_take = s_axi_arvalid & s_axi_arready;
    wire logic rd_istat = ar_take && s_axi_araddr == `DORC_OFS_IRQ_STAT;
    wire logic rd_hit =
        s_axi_araddr == `DORC_OFS_CTRL      || s_axi_araddr == `DORC_OFS_CH_STAT  ||
        s_axi_araddr == `DORC_OFS_MOD_STAT  || s_axi_araddr == `DORC_OFS_HOST_CTRL ||
        s_axi_araddr == `DORC_OFS_IRQ_STAT  || s_axi_araddr == `DORC_OFS_IRQ_MASK ||
        s_axi_araddr == `DORC_OFS_ASM_W0    || s_axi_araddr == `DORC_OFS_ASM_W1   ||
        s_axi_araddr == `DORC_OFS_ASM_W2;

    // Input assembly words are withheld until Run
    wire logic [`DORC_WORD_W-1:0] asm_w0 =
        in_run ? channel_readback_status_r[15:0] : `DORC_ZERO16;
    wire logic [`DORC_WORD_W-1:0] asm_w1 =
        in_run ? channel_readback_status_r[31:16] : `DORC_ZERO16;
    wire logic [`DORC_WORD_W-1:0] asm_w2 =
        in_run ? module_fault_status_r : `DORC_ZERO16;

    logic [31:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            `DORC_OFS_CTRL:      rd_mux = output_control_variable_r;
            `DORC_OFS_CH_STAT:   rd_mux = channel_readback_status_r;
            `DORC_OFS_MOD_STAT:  rd_mux = {16'h0000, module_fault_status_r};
            `DORC_OFS_HOST_CTRL: rd_mux = {30'h0000_0000, host_ctrl_r};
            `DORC_OFS_IRQ_STAT:  rd_mux = {28'h000_0000, irq_stat_r};
            `DORC_OFS_IRQ_MASK:  rd_mux = {28'h000_0000, irq_mask_r};
            `DORC_OFS_ASM_W0:    rd_mux = {16'h0000, asm_w0};
            `DORC_OFS_ASM_W1:    rd_mux = {16'h0000, asm_w1};
            `DORC_OFS_ASM_W2:    rd_mux = {16'h0000, asm_w2};
            default:             rd_mux = `DORC_ZERO32;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_addr_r     <= '0;
            w_data_r      <= `DORC_ZERO32;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DORC_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held_r & ~aw_take & ~s_axi_bvalid;
            s_axi_wready  <= ~w_held_r & ~w_take & ~s_axi_bvalid;
            if (aw_take) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `DORC_RESP_OKAY : `DORC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            output_control_variable_r <= '0;
            host_ctrl_r               <= 2'h0;
            irq_mask_r                <= '0;
            noncrit_r                 <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                output_control_variable_r <= ctrl_merged;
            end
            if (wr_hc) begin
                host_ctrl_r <= hc_merged[1:0];
            end
            if (wr_mask) begin
                irq_mask_r <= mask_merged[`DORC_IRQ_W-1:0];
            end
            // Unmapped write is a non-critical error reported upward
            noncrit_r <= wr_fire & ~wr_hit;
        end
    end

    // Data are latched at the address handshake, so a clearing read returns what it clears
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_busy_r     <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `DORC_ZERO32;
            s_axi_rresp   <= `DORC_RESP_OKAY;
        end else begin
            s_axi_arready <= ~rd_busy_r & ~ar_take;
            if (ar_take) begin
                rd_busy_r    <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? `DORC_RESP_OKAY : `DORC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                rd_busy_r    <= 1'b0;
            end
        end
    end

    // Edge history and the pin; the mask gates only the pin, status still records
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            in_run_d_r   <= 1'b0;
            hw_fault_d_r <= 1'b0;
            irq_o        <= 1'b0;
        end else begin
            in_run_d_r   <= in_run;
            hw_fault_d_r <= hw_fault;
            irq_o        <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Sticky status: a new event in the clearing read's cycle survives
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_stat_r <= '0;
        end else begin
            for (int b = 0; b < `DORC_IRQ_W; b++) begin
                if (ev_vec[b]) begin
                    irq_stat_r[b] <= 1'b1;
                end else if (rd_istat) begin
                    irq_stat_r[b] <= 1'b0;
                end
            end
        end
    end
endmodule : dorc_core
`default_nettype wire

/* File: rtl/dorc_cfg.svh */
// Register map, field positions and reset values for the discrete output run control block
`ifndef DORC_CFG_SVH
`define DORC_CFG_SVH

`define DORC_NUM_CH          32
`define DORC_WORD_W          16
`define DORC_IN_WORDS        3
`define DORC_OUT_WORDS       2
`define DORC_CFG_WORDS       0

`define DORC_ADDR_W          8
`define DORC_OFS_CTRL        8'h00
`define DORC_OFS_CH_STAT     8'h04
`define DORC_OFS_MOD_STAT    8'h08
`define DORC_OFS_HOST_CTRL   8'h0C
`define DORC_OFS_IRQ_STAT    8'h10
`define DORC_OFS_IRQ_MASK    8'h14
`define DORC_OFS_ASM_W0      8'h18
`define DORC_OFS_ASM_W1      8'h1C
`define DORC_OFS_ASM_W2      8'h20

`define DORC_BIT_LINK_FAULT  0
`define DORC_BIT_BROWNOUT    1
`define DORC_BIT_SERIAL      8
`define DORC_BIT_MOD_FAULT   15

`define DORC_HC_COMM_OK      0
`define DORC_HC_RUN          1

`define DORC_IRQ_W           4
`define DORC_IRQ_FAULT       0
`define DORC_IRQ_RUN_ENTER   1
`define DORC_IRQ_RUN_EXIT    2
`define DORC_IRQ_NONCRIT     3

`define DORC_ZERO32          32'h0000_0000
`define DORC_ZERO16          16'h0000
`define DORC_RESP_OKAY       2'h0
`define DORC_RESP_SLVERR     2'h2

`endif

/* File: rtl/dorc_pkg.sv */
// Types shared by the discrete output run control design
package dorc_pkg;
    typedef enum logic [1:0] {
        DORC_ST_WAIT_COMM = 2'h0,
        DORC_ST_IDLE      = 2'h1,
        DORC_ST_RUN       = 2'h2
    } dorc_mode_t;
endpackage : dorc_pkg

/* File: rtl/dorc_sync2.sv */
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module dorc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : dorc_sync2
`default_nettype wire

/* File: dv/dorc_out_model.sv */
// Output stage model that returns the driven channel states as readback
`timescale 1ns/1ps
`default_nettype none
module dorc_out_model #(
    parameter int NUM_CH = 32
) (
    input  wire logic              core_clk_i,
    input  wire logic [NUM_CH-1:0] drive_i,
    input  wire logic [NUM_CH-1:0] flip_i,
    output logic      [NUM_CH-1:0] readback_o
);
    // Flipped bits stand for stuck or failed output stages
    initial readback_o = '0;
    always @(posedge core_clk_i) readback_o <= drive_i ^ flip_i;
endmodule : dorc_out_model
`default_nettype wire

/* File: dv/dorc_core_asserts.sv */
// Port-level assertions for the run control block
`timescale 1ns/1ps
`default_nettype none
`include "dorc_cfg.svh"
module dorc_core_asserts #(
    parameter int NUM_CH = 32
) (
    input wire logic              core_clk_i,
    input wire logic              reset_i,
    input wire logic [7:0]        s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [7:0]        s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [NUM_CH-1:0] chan_drive_o,
    input wire logic [NUM_CH-1:0] chan_readback_i,
    input wire logic              link_fault_i,
    input wire logic              brownout_flag_i,
    input wire logic              serial_invalid_flag_i,
    input wire logic              irq_o
);
    logic [7:0] ar_r;
    logic [7:0] aw_r;
    wire ar_ok  = ar_r[1:0] == 2'h0 && ar_r <= `DORC_OFS_ASM_W2;
    wire aw_ok  = aw_r[1:0] == 2'h0 && aw_r <= `DORC_OFS_ASM_W2;
    wire any_f  = link_fault_i | brownout_flag_i | serial_invalid_flag_i;
    wire mod_rd = s_axi_rvalid && ar_r == `DORC_OFS_MOD_STAT;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ar_r <= 8'h00;
            aw_r <= 8'h00;
        end else begin
            if (s_axi_arvalid && s_axi_arready) ar_r <= s_axi_araddr;
            if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // Pins pass a two-flop synchroniser, so the fault must stand a few edges
    sequence fault_held; any_f [*4]; endsequence
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_fault_drive_off: assert property (fault_held |-> chan_drive_o == '0)
        else $error("drive not off under fault");
    a_unused_zero: assert property (mod_rd |-> (s_axi_rdata[14:2] & 13'h1FBF) == 13'h0)
        else $error("unused status bits set");
    a_fault_or: assert property (mod_rd |->
        s_axi_rdata[15] == (s_axi_rdata[0] | s_axi_rdata[1] | s_axi_rdata[8]))
        else $error("module fault bit wrong");
    a_write_resp: assert property (wr_take |-> ##[1:4] s_axi_bvalid)
        else $error("write response missing");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during response");
    a_wr_unmapped: assert property (s_axi_bvalid && !aw_ok |-> s_axi_bresp == `DORC_RESP_SLVERR)
        else $error("unmapped write not refused");
    a_rd_unmapped: assert property (s_axi_rvalid && !ar_ok |->
        s_axi_rresp == `DORC_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule : dorc_core_asserts
bind dorc_core dorc_core_asserts #(.NUM_CH(NUM_CH)) u_chk (.*);
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the run control block
`timescale 1ns/1ps
`default_nettype none
`include "dorc_cfg.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, flip = 32'h0, c, c2, d, seed = 32'hE573;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [2:0] flt = 3'h0;
    logic [1:0] r;
    logic [3:0] strb = 4'hF;
    wire awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, drive, rb;
    int bad_count = 0;
    int total_checks = 0;
    always #2.5 clk = ~clk;
    dorc_core dut_u (.core_clk_i(clk), .reset_i(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .chan_drive_o(drive), .chan_readback_i(rb),
        .link_fault_i(flt[0]), .brownout_flag_i(flt[1]),
        .serial_invalid_flag_i(flt[2]), .irq_o(irq));
    dorc_out_model model_u (.core_clk_i(clk), .drive_i(drive), .flip_i(flip), .readback_o(rb));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [31:0] mexp(input logic [2:0] f);
        return {16'h0, |f, 6'h00, f[2], 6'h00, f[1], f[0]};
    endfunction : mexp
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t %s got %h want %h", $time, m, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ad = 1'b0;
        logic wd = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            ad = ad | awready;
            wd = wd | wready;
        end
        while (!bvalid) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string m);
        rd(a);
        chk(d, e, m);
    endtask : rc
    task automatic settle();
        repeat (10) @(posedge clk);
    endtask : settle
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        #100000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rc(`DORC_OFS_CTRL, 32'h0, "ctrl reset");
        rc(`DORC_OFS_MOD_STAT, 32'h0, "status reset");
        rc(`DORC_OFS_ASM_W2, 32'h0, "assembly before run");
        chk(drive, 32'h0, "drive after reset");
        c = xs();
        wr(`DORC_OFS_CTRL, c);
        wr(`DORC_OFS_HOST_CTRL, 32'h1);
        settle();
        chk(drive, 32'h0, "drive without run");
        rc(`DORC_OFS_ASM_W0, 32'h0, "assembly idle");
        wr(`DORC_OFS_HOST_CTRL, 32'h3);
        settle();
        chk(drive, c, "drive on run entry");
        chk({30'h0, r}, 32'h0, "mapped write okay");
        rc(`DORC_OFS_IRQ_STAT, 32'h2, "run entry event");
        $display("test startup done");
        // All-ones then random control words, with some readbacks disagreeing with the drive
        for (int i = 0; i < 6; i++) begin
            c = (i == 0) ? 32'hFFFF_FFFF : xs();
            flip <= (i < 2) ? 32'h0 : xs();
            wr(`DORC_OFS_CTRL, c);
            settle();
            chk(drive, c, "drive in run");
            rc(`DORC_OFS_CH_STAT, c ^ flip, "channel status");
            rc(`DORC_OFS_ASM_W0, {16'h0, c[15:0] ^ flip[15:0]}, "word 0");
            rc(`DORC_OFS_ASM_W1, {16'h0, c[31:16] ^ flip[31:16]}, "word 1");
            rc(`DORC_OFS_ASM_W2, 32'h0, "word 2");
        end
        flip <= 32'h0;
        $display("test run data done");
        wr(`DORC_OFS_HOST_CTRL, 32'h1);
        c2 = xs();
        wr(`DORC_OFS_CTRL, c2);
        settle();
        chk(drive, 32'h0, "drive after run left");
        wr(`DORC_OFS_HOST_CTRL, 32'h3);
        settle();
        chk(drive, c2, "drive on reentry");
        rc(`DORC_OFS_IRQ_STAT, 32'h6, "run exit and entry events");
        $display("test run exit done");
        wr(`DORC_OFS_IRQ_MASK, 32'h1);
        for (int k = 0; k < 3; k++) begin
            rd(`DORC_OFS_IRQ_STAT);
            flt <= 3'h1 << k;
            settle();
            chk(drive, 32'h0, "drive under fault");
            rc(`DORC_OFS_MOD_STAT, mexp(3'h1 << k), "fault status");
            flip <= 32'hFFFF_FFFF;
            settle();
            rc(`DORC_OFS_CH_STAT, c2, "frozen status");
            chk({31'h0, irq}, 32'h1, "fault interrupt");
            rc(`DORC_OFS_IRQ_STAT, 32'h1, "fault event");
            settle();
            chk({31'h0, irq}, 32'h0, "interrupt cleared");
            flt <= 3'h0;
            flip <= 32'h0;
            settle();
            chk(drive, c2, "drive after fault");
        end
        $display("test faults done");
        strb <= 4'h1;
        wr(`DORC_OFS_CTRL, 32'h0);
        strb <= 4'hF;
        c2[7:0] = 8'h00;
        settle();
        chk(drive, c2, "byte lane write");
        wr(8'h24, 32'hFFFF_FFFF);
        chk({30'h0, r}, {30'h0, `DORC_RESP_SLVERR}, "unmapped write");
        rc(8'h30, 32'h0, "unmapped read");
        chk({30'h0, r}, {30'h0, `DORC_RESP_SLVERR}, "unmapped read resp");
        rd(`DORC_OFS_IRQ_STAT);
        chk({31'h0, d[`DORC_IRQ_NONCRIT]}, 32'h1, "noncritical event");
        chk(drive, c2, "drive after unmapped");
        $display("test unmapped done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
